/* File: logic/pin_function_select_consts.svh */
// Offsets, field positions, write masks and reset values of the pin function selection block.
`ifndef PIN_FUNCTION_SELECT_CONSTS_SVH
`define PIN_FUNCTION_SELECT_CONSTS_SVH

// Register indices; the byte address on the bus is four times the index.
`define IDX_P0_4            16'hA054
`define IDX_P0_5            16'hA055
`define IDX_P0_6            16'hA056
`define IDX_P0_7            16'hA057
`define IDX_P1_0            16'hA058
`define IDX_P1_1            16'hA059
`define IDX_P1_2            16'hA05A
`define IDX_IRQ_STATUS      16'hA0F0
`define IDX_IRQ_MASK        16'hA0F1
`define IDX_PAD_ANALOG      16'hA0F2

// Number of pins and their positions in the pin vectors.
`define NUM_PINS            7
`define PIN_P0_4            0
`define PIN_P0_5            1
`define PIN_P0_6            2
`define PIN_P0_7            3
`define PIN_P1_0            4
`define PIN_P1_1            5
`define PIN_P1_2            6

// Field positions inside a selection register.
`define BIT_GPIO            0
`define BIT_IRQ0            1
`define BIT_IRQ1            2
`define BIT_ALT4            4
`define BIT_ALT5            5
`define BIT_ALT6            6
`define BIT_CONV            7

// Implemented bits of each selection register.
`define MASK_P0_4           8'h87
`define MASK_P0_5           8'h97
`define MASK_P0_6           8'hB7
`define MASK_P0_7           8'hB7
`define MASK_P1_0           8'hB7
`define MASK_P1_1           8'hB7
`define MASK_P1_2           8'hF7

// Reset values.
`define SEL_RESET           8'h00
`define IRQ_RESET           2'h0
`define PAD_ANALOG_RESET    7'h00

`endif

/* File: logic/pin_function_select_pkg.sv */
// Types shared by the pin function selection block.
`default_nettype none
package pin_function_select_pkg;

  typedef struct packed {
    logic conv_connect;
    logic alt6;
    logic alt5;
    logic alt4;
    logic unused3;
    logic irq1;
    logic irq0;
    logic gpio;
  } pin_sel_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] index;
  } bus_req_t;

  typedef struct packed {
    logic out;
    logic oe_n;
  } pad_drive_t;

endpackage
`default_nettype wire

/* File: logic/pin_function_select_p04_p12.sv */
// Function selection for pins P0.4 to P1.2 with an AHB-Lite register slave.
//
// Overview of operation
// - Group-1 select bit feeds the pin input into interrupt group 1.
// - Group-0 select bit feeds the pin input into interrupt group 0.
// - Any number of pins may join one interrupt group together.
// - One pin may sit in both interrupt groups at once.
// - Bit 0 enables general I/O; registers reset to 0x00.
// - Bit 7 connects the pin to its converter channel.
// - P0.5 bit 4 routes the pin as motor PWM emergency input.
// - P0.6 bits 4 and 5 drive serial 0 or serial 2 transmit.
// - P0.7 bits 4 and 5 feed serial 0 or serial 2 receive.
// - Bit 5 on P1.0 and P1.2 drives PWM channel A positive.
// - Bit 5 on P1.1 drives PWM channel A negative.
// - Bit 4 on P1.0 connects capture/compare unit 0 pin.
// - Bit 4 on P1.1 connects capture/compare unit 1 pin.
// - Bit 4 on P1.2 connects capture/compare unit 2 pin.
// - Bit 6 on P1.2 connects two-wire slave data, open-drain.
// - Pad analog connect bit attaches pin to analog; reset disabled.
`timescale 1ns/1ps
`default_nettype none
`include "pin_function_select_consts.svh"

module pin_function_select_p04_p12 #(
  parameter int HADDR_W = 32
) (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [HADDR_W-1:0]    haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  input  wire logic [`NUM_PINS-1:0]  pad_in,
  output logic      [`NUM_PINS-1:0]  pad_out,
  output logic      [`NUM_PINS-1:0]  pad_oe_n,
  output logic      [`NUM_PINS-1:0]  pad_analog_connect,
  output logic      [`NUM_PINS-1:0]  conv_connect,
  input  wire logic [`NUM_PINS-1:0]  gpio_out,
  input  wire logic [`NUM_PINS-1:0]  gpio_oe_n,
  output logic      [`NUM_PINS-1:0]  gpio_in,
  output logic                       pin_irq_group0,
  output logic                       pin_irq_group1,
  output logic                       pwm_emergency_input,
  input  wire logic                  serial0_txd,
  input  wire logic                  serial2_txd,
  output logic                       serial0_rxd,
  output logic                       serial2_rxd,
  input  wire logic                  motor_pwm_a_pos,
  input  wire logic                  motor_pwm_a_neg,
  input  wire logic [2:0]            capcomp_out,
  input  wire logic [2:0]            capcomp_oe_n,
  output logic      [2:0]            capcomp_in,
  input  wire logic                  twowire_data_oe_n,
  output logic                       twowire_data_in,
  output logic                       irq
);

  generate
    if (HADDR_W < 18 || HADDR_W > 32) begin : g_bad_haddr
      $error("HADDR_W must lie between 18 and 32");
    end
  endgenerate

  localparam logic [7:0] WRITE_MASK [`NUM_PINS] = '{
    `MASK_P0_4, `MASK_P0_5, `MASK_P0_6, `MASK_P0_7,
    `MASK_P1_0, `MASK_P1_1, `MASK_P1_2
  };
  localparam logic [15:0] SEL_INDEX [`NUM_PINS] = '{
    `IDX_P0_4, `IDX_P0_5, `IDX_P0_6, `IDX_P0_7,
    `IDX_P1_0, `IDX_P1_1, `IDX_P1_2
  };

  pin_function_select_pkg::pin_sel_t   sel [`NUM_PINS];
  pin_function_select_pkg::bus_req_t   req;
  pin_function_select_pkg::pad_drive_t next_drive [`NUM_PINS];
  logic [1:0]                          irq_status;
  logic [1:0]                          irq_mask;
  logic [1:0]                          group_prev;
  logic [1:0]                          group_rise;
  logic [31:0]                         wide_addr;
  logic                                addr_phase;
  logic                                status_read;
  logic [31:0]                         next_rdata;
  logic                                next_group0;
  logic                                next_group1;
  logic [`NUM_PINS-1:0]                next_gpio_in;

  // The slave never stretches a transfer, so every access completes in one data phase.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wide_addr = 32'(haddr);
  assign addr_phase = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req <= '0;
    end else if (hready) begin
      req.valid <= addr_phase && (wide_addr[31:18] == 14'h0000);
      req.write <= hwrite;
      req.index <= wide_addr[17:2];
    end
  end

  // Selection registers take the write in its data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < `NUM_PINS; i++) begin
        sel[i] <= `SEL_RESET;
      end
    end else if (req.valid && req.write) begin
      for (int i = 0; i < `NUM_PINS; i++) begin
        if (req.index == SEL_INDEX[i]) begin
          sel[i] <= hwdata[7:0] & WRITE_MASK[i];
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pad_analog_connect <= `PAD_ANALOG_RESET;
    end else if (req.valid && req.write && req.index == `IDX_PAD_ANALOG) begin
      pad_analog_connect <= hwdata[`NUM_PINS-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask <= `IRQ_RESET;
    end else if (req.valid && req.write && req.index == `IDX_IRQ_MASK) begin
      irq_mask <= hwdata[1:0];
    end
  end

  // Read data is driven straight from the registers during the data phase.
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (req.valid && !req.write) begin
      for (int i = 0; i < `NUM_PINS; i++) begin
        if (req.index == SEL_INDEX[i]) begin
          next_rdata = {24'h00_0000, sel[i] & WRITE_MASK[i]};
        end
      end
      case (req.index)
        `IDX_IRQ_STATUS: next_rdata = {30'h0000_0000, irq_status};
        `IDX_IRQ_MASK:   next_rdata = {30'h0000_0000, irq_mask};
        `IDX_PAD_ANALOG: next_rdata = {25'h000_0000, pad_analog_connect};
        default:         ;
      endcase
    end
  end
  assign hrdata = next_rdata;
  assign status_read = req.valid && !req.write && req.index == `IDX_IRQ_STATUS;

  // Group conditions, registered so that the outputs come from flip-flops.
  always_comb begin
    next_group0 = 1'b0;
    next_group1 = 1'b0;
    for (int i = 0; i < `NUM_PINS; i++) begin
      next_group0 = next_group0 | (sel[i].irq0 & pad_in[i]);
      next_group1 = next_group1 | (sel[i].irq1 & pad_in[i]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_irq_group0 <= 1'b0;
      pin_irq_group1 <= 1'b0;
      group_prev     <= 2'h0;
    end else begin
      pin_irq_group0 <= next_group0;
      pin_irq_group1 <= next_group1;
      group_prev     <= {pin_irq_group1, pin_irq_group0};
    end
  end

  // A rising group condition is the event; a new event beats a clearing read.
  assign group_rise = {pin_irq_group1, pin_irq_group0} & ~group_prev;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= `IRQ_RESET;
    end else begin
      irq_status <= (status_read ? 2'h0 : irq_status) | group_rise;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // Pad drive: peripherals outrank general I/O; an unclaimed pad is released.
  always_comb begin
    for (int i = 0; i < `NUM_PINS; i++) begin
      next_drive[i] = '{out: 1'b0, oe_n: 1'b1};
      if (sel[i].gpio) begin
        next_drive[i] = '{out: gpio_out[i], oe_n: gpio_oe_n[i]};
      end
    end
    if (sel[`PIN_P0_6].alt5) begin
      next_drive[`PIN_P0_6] = '{out: serial2_txd, oe_n: 1'b0};
    end
    if (sel[`PIN_P0_6].alt4) begin
      next_drive[`PIN_P0_6] = '{out: serial0_txd, oe_n: 1'b0};
    end
    if (sel[`PIN_P1_0].alt5) begin
      next_drive[`PIN_P1_0] = '{out: motor_pwm_a_pos, oe_n: 1'b0};
    end
    if (sel[`PIN_P1_0].alt4) begin
      next_drive[`PIN_P1_0] = '{out: capcomp_out[0], oe_n: capcomp_oe_n[0]};
    end
    if (sel[`PIN_P1_1].alt5) begin
      next_drive[`PIN_P1_1] = '{out: motor_pwm_a_neg, oe_n: 1'b0};
    end
    if (sel[`PIN_P1_1].alt4) begin
      next_drive[`PIN_P1_1] = '{out: capcomp_out[1], oe_n: capcomp_oe_n[1]};
    end
    if (sel[`PIN_P1_2].alt5) begin
      next_drive[`PIN_P1_2] = '{out: motor_pwm_a_pos, oe_n: 1'b0};
    end
    if (sel[`PIN_P1_2].alt4) begin
      next_drive[`PIN_P1_2] = '{out: capcomp_out[2], oe_n: capcomp_oe_n[2]};
    end
    // The data line only ever pulls low, so it can share the wire with other open-drain drivers.
    if (sel[`PIN_P1_2].alt6) begin
      next_drive[`PIN_P1_2] = '{out: 1'b0, oe_n: twowire_data_oe_n};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pad_out  <= '0;
      pad_oe_n <= '1;
    end else begin
      for (int i = 0; i < `NUM_PINS; i++) begin
        pad_out[i]  <= next_drive[i].out;
        pad_oe_n[i] <= next_drive[i].oe_n;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < `NUM_PINS; i++) begin
      next_gpio_in[i] = sel[i].gpio & pad_in[i];
    end
  end

  // Inputs of unselected peripherals rest at their idle level.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gpio_in             <= '0;
      conv_connect        <= '0;
      pwm_emergency_input <= 1'b0;
      serial0_rxd         <= 1'b1;
      serial2_rxd         <= 1'b1;
      capcomp_in          <= 3'h0;
      twowire_data_in     <= 1'b1;
    end else begin
      gpio_in <= next_gpio_in;
      for (int i = 0; i < `NUM_PINS; i++) begin
        conv_connect[i] <= sel[i].conv_connect;
      end
      pwm_emergency_input <= sel[`PIN_P0_5].alt4 & pad_in[`PIN_P0_5];
      serial0_rxd <= sel[`PIN_P0_7].alt4 ? pad_in[`PIN_P0_7] : 1'b1;
      serial2_rxd <= sel[`PIN_P0_7].alt5 ? pad_in[`PIN_P0_7] : 1'b1;
      capcomp_in[0] <= sel[`PIN_P1_0].alt4 & pad_in[`PIN_P1_0];
      capcomp_in[1] <= sel[`PIN_P1_1].alt4 & pad_in[`PIN_P1_1];
      capcomp_in[2] <= sel[`PIN_P1_2].alt4 & pad_in[`PIN_P1_2];
      twowire_data_in <= sel[`PIN_P1_2].alt6 ? pad_in[`PIN_P1_2] : 1'b1;
    end
  end

endmodule // pin_function_select_p04_p12
`default_nettype wire

/* File: verif/pin_function_select_checker.sv */
// Port-level assertions for the pin function selection block.
`timescale 1ns/1ps
`default_nettype none
`include "pin_function_select_consts.svh"
module pin_function_select_checker #(
  parameter int HADDR_W = 32
) (
  input wire logic                 hclk,
  input wire logic                 hresetn,
  input wire logic                 hsel,
  input wire logic [HADDR_W-1:0]   haddr,
  input wire logic [1:0]           htrans,
  input wire logic                 hready,
  input wire logic [31:0]          hrdata,
  input wire logic                 hreadyout,
  input wire logic                 hresp,
  input wire logic [`NUM_PINS-1:0] pad_in,
  input wire logic [`NUM_PINS-1:0] gpio_in,
  input wire logic [2:0]           capcomp_in,
  input wire logic                 serial0_rxd,
  input wire logic                 serial2_rxd,
  input wire logic                 twowire_data_in,
  input wire logic                 pin_irq_group0,
  input wire logic                 pin_irq_group1,
  input wire logic                 pwm_emergency_input
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Every mapped register sits in the one 4 KiB window at byte 0x28000.
  sequence unmapped_access;
    hsel && hready && htrans[1] && haddr[17:12] != 6'h28;
  endsequence
  sequence pads_low;
    pad_in == '0;
  endsequence
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus slave not ready or not okay");
  unmapped_zero_a: assert property (unmapped_access |=> hrdata == 32'h0)
    else $error("unmapped access returned data");
  group0_idle_a: assert property (pads_low |=> !pin_irq_group0)
    else $error("group 0 high with no pin high");
  group1_idle_a: assert property (pads_low |=> !pin_irq_group1)
    else $error("group 1 high with no pin high");
  emergency_src_a: assert property (pwm_emergency_input |-> $past(pad_in[1]))
    else $error("emergency input high while its pin was low");
  gpio_src_a: assert property ((gpio_in & ~$past(pad_in)) == '0)
    else $error("general input high while its pin was low");
  capcomp_src_a: assert property ((capcomp_in & ~$past(pad_in[6:4])) == 3'h0)
    else $error("capture input high while its pin was low");
  rxd_src_a: assert property ((!serial0_rxd || !serial2_rxd) |-> !$past(pad_in[3]))
    else $error("receive input low while its pin was high");
  twowire_src_a: assert property (!twowire_data_in |-> !$past(pad_in[6]))
    else $error("two-wire data low while its pin was high");
endmodule // pin_function_select_checker

bind pin_function_select_p04_p12 pin_function_select_checker #(.HADDR_W(HADDR_W)) chk_inst (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hready, .hrdata, .hreadyout, .hresp, .pad_in,
  .gpio_in, .capcomp_in, .serial0_rxd, .serial2_rxd, .twowire_data_in, .pin_irq_group0,
  .pin_irq_group1, .pwm_emergency_input);
`default_nettype wire

/* File: verif/pad_ring_model.sv */
// Pad ring model: resolves each pin from the block's drive and outside pull-downs.
`timescale 1ns/1ps
`default_nettype none
module pad_ring_model (
  input  wire logic [6:0] pad_out,
  input  wire logic [6:0] pad_oe_n,
  input  wire logic [6:0] ext_low,
  output logic      [6:0] pad_in
);
  // Wired-AND with a pull-up: a floating pin reads high, any low driver wins.
  // A push-pull high against an outside low is shown as low, not as a fault.
  assign pad_in = (pad_oe_n | pad_out) & ~ext_low;
endmodule // pad_ring_model
`default_nettype wire

/* File: verif/test_pin_function_select_p04_p12.sv */
// Self-checking bench for the pin function selection block.
`timescale 1ns/1ps
`default_nettype none
`include "pin_function_select_consts.svh"
module test_pin_function_select_p04_p12;
  logic        hclk, hresetn, hsel, hwrite, hready, hresp, irq, serial0_rxd, serial2_rxd;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [6:0]  pad_in, pad_out, pad_oe_n, pad_analog_connect, conv_connect;
  logic [6:0]  gpio_out, gpio_oe_n, gpio_in, ext_low;
  logic        pin_irq_group0, pin_irq_group1, pwm_emergency_input, serial0_txd, serial2_txd;
  logic        motor_pwm_a_pos, motor_pwm_a_neg, twowire_data_oe_n, twowire_data_in;
  logic [2:0]  capcomp_out, capcomp_oe_n, capcomp_in;
  int          mismatches, checks;

  pin_function_select_p04_p12 dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp, .pad_in, .pad_out,
    .pad_oe_n, .pad_analog_connect, .conv_connect, .gpio_out, .gpio_oe_n, .gpio_in,
    .pin_irq_group0, .pin_irq_group1, .pwm_emergency_input, .serial0_txd, .serial2_txd,
    .serial0_rxd, .serial2_rxd, .motor_pwm_a_pos, .motor_pwm_a_neg, .capcomp_out,
    .capcomp_oe_n, .capcomp_in, .twowire_data_oe_n, .twowire_data_in, .irq);
  pad_ring_model pads (.pad_out, .pad_oe_n, .ext_low, .pad_in);

  task automatic conclude();
    if (mismatches == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic bus(input logic w, input logic [15:0] idx, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {14'h0, idx, 2'h0};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, idx, d, r);
  endtask
  task automatic rdc(input string n, input logic [15:0] idx, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, idx, 32'h0, r);
    chk(n, e, r);
  endtask

  task automatic t_regs();
    logic [7:0] m [7] = '{8'h87, 8'hB7 & 8'h97, 8'hB7, 8'hB7, 8'hB7, 8'hB7, 8'hF7};
    rdc("status reset", `IDX_IRQ_STATUS, 32'h0);
    rdc("mask reset", `IDX_IRQ_MASK, 32'h0);
    rdc("analog reset", `IDX_PAD_ANALOG, 32'h0);
    for (int i = 0; i < 7; i++) begin
      rdc("select reset", 16'(`IDX_P0_4 + i), 32'h0);
      wr(16'(`IDX_P0_4 + i), 32'hFFFF_FFFF);
      rdc("select bits", 16'(`IDX_P0_4 + i), {24'h0, m[i]});
      wr(16'(`IDX_P0_4 + i), 32'h0);
    end
    rdc("unmapped", 16'h1000, 32'h0);
  endtask

  // P0.4 and P1.2 join group 0; P0.5 sits in both groups.
  task automatic t_irq();
    wr(`IDX_P0_4, 32'h02);
    wr(`IDX_P1_2, 32'h02);
    wr(`IDX_P0_5, 32'h06);
    wr(`IDX_IRQ_MASK, 32'h03);
    tick(3);
    rdc("status flush", `IDX_IRQ_STATUS, 32'h0);
    ext_low <= 7'h3F;
    tick(5);
    chk("group0 from P1.2", 1, pin_irq_group0);
    chk("group1 quiet", 0, pin_irq_group1);
    chk("irq raised", 1, irq);
    rdc("status group0", `IDX_IRQ_STATUS, 32'h1);
    tick(3);
    chk("irq cleared", 0, irq);
    // Group 0 stays high across the hand-over, so only group 1 may log an event.
    ext_low <= 7'h7D;
    tick(5);
    chk("group0 from P0.5", 1, pin_irq_group0);
    chk("group1 from P0.5", 1, pin_irq_group1);
    rdc("status group1", `IDX_IRQ_STATUS, 32'h2);
    wr(`IDX_IRQ_MASK, 32'h02);
    ext_low <= 7'h7F;
    tick(4);
    ext_low <= 7'h7E;
    tick(5);
    chk("irq masked", 0, irq);
    rdc("status masked", `IDX_IRQ_STATUS, 32'h1);
    wr(`IDX_P0_4, 32'h0);
    wr(`IDX_P1_2, 32'h0);
    wr(`IDX_P0_5, 32'h0);
  endtask

  task automatic t_route();
    ext_low <= 7'h08;
    wr(`IDX_P0_4, 32'h81);
    wr(`IDX_P0_5, 32'h10);
    wr(`IDX_P0_6, 32'h10);
    wr(`IDX_P0_7, 32'h10);
    wr(`IDX_P1_0, 32'h20);
    wr(`IDX_P1_1, 32'h20);
    wr(`IDX_P1_2, 32'h20);
    wr(`IDX_PAD_ANALOG, 32'h60);
    tick(3);
    chk("pad out", 7'h55, pad_out);
    chk("pad oe_n", 7'h0A, pad_oe_n);
    chk("general in", 7'h01, gpio_in);
    chk("emergency", 1, pwm_emergency_input);
    chk("receive", 2'b01, {serial0_rxd, serial2_rxd});
    chk("converter", 7'h01, conv_connect);
    chk("analog", 7'h60, pad_analog_connect);
    capcomp_oe_n <= 3'h2;
    wr(`IDX_P0_5, 32'h0);
    wr(`IDX_P0_6, 32'h20);
    wr(`IDX_P0_7, 32'h20);
    wr(`IDX_P1_0, 32'h30);
    wr(`IDX_P1_1, 32'h30);
    wr(`IDX_P1_2, 32'hF0);
    tick(3);
    chk("pad out alt", 7'h11, pad_out);
    chk("pad oe_n alt", 7'h2A, pad_oe_n);
    chk("capture in", 3'h3, capcomp_in);
    chk("two-wire in", 0, twowire_data_in);
    chk("receive alt", 2'b10, {serial0_rxd, serial2_rxd});
    chk("emergency off", 0, pwm_emergency_input);
    // Unit 2 releases its pin, which tells its drive apart from the always-on PWM output.
    capcomp_oe_n <= 3'h4;
    wr(`IDX_P1_2, 32'h30);
    tick(3);
    chk("pad out unit2", 7'h51, pad_out);
    chk("pad oe_n unit2", 7'h4A, pad_oe_n);
    chk("capture in unit2", 3'h5, capcomp_in);
  endtask

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  initial begin
    tick(20000);
    mismatches++;
    conclude();
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    {gpio_out, gpio_oe_n, ext_low, capcomp_out, capcomp_oe_n} = {7'h01, 7'h7E, 7'h7F, 3'h5, 3'h0};
    {serial0_txd, serial2_txd, motor_pwm_a_pos, motor_pwm_a_neg, twowire_data_oe_n} = 5'h14;
    tick(5);
    hresetn <= 1'b1;
    tick(1);
    t_regs();
    t_irq();
    t_route();
    conclude();
  end
endmodule // test_pin_function_select_p04_p12
`default_nettype wire
